/* logic/monitor_cfg_map.svh */
// Register offsets, reset values and field positions of the channel and acoustics
// configuration group.
// Assumes inclusion by bare name from design files.
`ifndef MONITOR_CFG_MAP_SVH
`define MONITOR_CFG_MAP_SVH

`define ADDR_CHANNEL_MODE 8'h16
`define ADDR_ATTEN_FIRST 8'h18
`define ADDR_ATTEN_SECOND 8'h19
`define ADDR_ACOUSTICS_FIRST 8'h1A
`define ADDR_CONTROL 8'h30

`define RESET_CHANNEL_MODE 8'h00
`define RESET_ATTEN_FIRST 8'hFF
`define RESET_ATTEN_SECOND 8'h37
`define RESET_ACOUSTICS_FIRST 8'h00
`define RESET_CONTROL 8'h00

`define ATTEN_FIRST_RW_MASK 8'hFE
`define ATTEN_FIRST_RO_VALUE 8'h01
`define FULL_MASK 8'hFF
`define ATTEN1_KEEP_HI 7
`define ATTEN1_KEEP_LO 1
`define ATTEN2_LOW_HI 2
`define ATTEN2_LOW_LO 0
`define ATTEN2_HIGH_HI 5
`define ATTEN2_HIGH_LO 4
`define RESET_ATTEN_FIRST_KEEP 7'h7F
`define RESET_ATTEN_SECOND_KEEP 5'h1F

`define BIT_PIN5_EXTRA 0
`define BIT_PIN6_EXTRA 1
`define BIT_SINGLE_MODE 2
`define SEL_HI 7
`define SEL_LO 3

`define BIT_ACOUSTICS_OUT1 0
`define BIT_ACOUSTICS_OUT2 1
`define RAMP1_HI 4
`define RAMP1_LO 2
`define RAMP2_HI 7
`define RAMP2_LO 5

`define BIT_CTRL_LOCK 0
`define BIT_CTRL_SOFT_RESET 1

`define ZERO_BYTE 8'h00
`define LAST_CHANNEL_CODE 5'h11
`define FIRST_CHANNEL_CODE 5'h00

`endif

/* logic/monitor_cfg_pkg.sv */
// Types shared by the configuration group.
// Assumes the map header for numeric constants.
package monitor_cfg_pkg;
	typedef enum logic [4:0] {
		chan_pin26 = 5'h00,
		chan_remote1 = 5'h01,
		chan_remote2 = 5'h02,
		chan_remote3 = 5'h03,
		chan_local = 5'h04,
		chan_12v_first = 5'h05,
		chan_12v_second = 5'h06,
		chan_12v_third = 5'h07,
		chan_3v3 = 5'h08,
		chan_pin15 = 5'h09,
		chan_pin19 = 5'h0A,
		chan_5v = 5'h0B,
		chan_pin23 = 5'h0C,
		chan_pin24 = 5'h0D,
		chan_pin25 = 5'h0E,
		chan_1v5_first = 5'h10,
		chan_1v5_second = 5'h11
	} channel_code_type;
	typedef logic [7:0] byte_type;
	typedef logic [5:0] duty_step_type;
endpackage

/* logic/config_byte_reg.sv */
// One configuration byte with write mask, lock and software return to default.
// Assumes writes arrive as one-cycle strobes on mclk.
`timescale 1ns/100ps
module config_byte_reg #(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] WRITE_MASK = 8'hFF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic clk_en,
	// Control
	input wire logic write_en,
	input wire logic locked,
	input wire logic soft_reset,
	input wire logic [7:0] write_data,
	// Value
	output logic [7:0] value
);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			value <= RESET_VALUE;
		end else if (clk_en) begin
			if (soft_reset) begin
				value <= RESET_VALUE;
			end else if (write_en && !locked) begin
				value <= (write_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
			end
		end
	end
endmodule

/* logic/ramp_step_lookup.sv */
// Turns a 3-bit ramp-rate code into a registered per-slot duty increase.
// Assumes the code is stable logic on mclk.
`timescale 1ns/100ps
module ramp_step_lookup (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic clk_en,
	// Code in, step out
	input wire logic [2:0] rate_code,
	output logic [5:0] duty_step
);
	logic [5:0] next_duty_step;

	always_comb begin
		unique case (rate_code)
			3'h0: next_duty_step = 6'h01;
			3'h1: next_duty_step = 6'h02;
			3'h2: next_duty_step = 6'h03;
			3'h3: next_duty_step = 6'h05;
			3'h4: next_duty_step = 6'h08;
			3'h5: next_duty_step = 6'h0C;
			3'h6: next_duty_step = 6'h18;
			3'h7: next_duty_step = 6'h30;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			duty_step <= 6'h01;
		end else if (clk_en) begin
			duty_step <= next_duty_step;
		end
	end
endmodule

/* logic/monitor_channel_acoustics_config.sv */
// Channel mode, attenuator and acoustics configuration registers with their
// decoded outputs for the converter sequencer, input stage and fan drive.
// Assumes a same-clock register port master; reads answer one cycle later.
//
// Function
// - Mode bit 0 enables pin 5 extra output.
// - Mode bit 1 enables pin 6 extra output.
// - Mode bit 2 selects repeated single-channel conversion.
// - Mode bits 7:3 choose the single channel.
// - Codes 0,5,6,7: pin 26, 12 V inputs.
// - Codes 1 to 4: remote and local sensors.
// - Codes 8 to 11: 3.3 V, pins, 5 V.
// - Codes 12 to 14: pins 23, 24, 25.
// - Codes 16, 17: first and second 1.5 V.
// - First attenuator bits 1..7 control seven pins.
// - Second attenuator bits 0,1,2,4,5 control five pins.
// - Second attenuator reserved bits store, reset zero.
// - Acoustics bit 0 enables fan output 1 ramping.
// - Acoustics bit 1 enables fan output 2 ramping.
// - Acoustics bits 4:2 hold output 1 rate.
// - Acoustics bits 7:5 hold output 2 rate.
// - Rate code maps to duty increase per slot.
// - Defaults at power-on, lockable, software reset restores all but the lock.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "monitor_cfg_map.svh"

module monitor_channel_acoustics_config (
	// Clock, reset and enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic clk_en,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output monitor_cfg_pkg::byte_type reg_rdata,
	// Converter sequencer
	input wire logic seq_advance,
	output logic single_channel_mode,
	output logic [4:0] convert_channel,
	// Extra output function on general pins
	output logic pin5_extra_output_enable,
	output logic pin6_extra_output_enable,
	// Attenuators, one bit per pin, 1 keeps it
	output logic [6:0] atten_first_keep,
	output logic [4:0] atten_second_keep,
	// Fan drive ramping
	output logic acoustics_enable_out1,
	output logic acoustics_enable_out2,
	output monitor_cfg_pkg::duty_step_type duty_step_out1,
	output monitor_cfg_pkg::duty_step_type duty_step_out2,
	// Lock state
	output logic locked
);
	import monitor_cfg_pkg::*;

	// ------------------------------------------------------------
	// Decode and storage
	// ------------------------------------------------------------
	logic [7:0] channel_mode_value;
	logic [7:0] atten_first_value;
	logic [7:0] atten_second_value;
	logic [7:0] acoustics_value;
	logic [7:0] control_value;
	logic wr_mode;
	logic wr_atten1;
	logic wr_atten2;
	logic wr_acou;
	logic wr_ctrl;
	logic soft_reset;

	assign wr_mode = reg_write && (reg_addr == `ADDR_CHANNEL_MODE);
	assign wr_atten1 = reg_write && (reg_addr == `ADDR_ATTEN_FIRST);
	assign wr_atten2 = reg_write && (reg_addr == `ADDR_ATTEN_SECOND);
	assign wr_acou = reg_write && (reg_addr == `ADDR_ACOUSTICS_FIRST);
	assign wr_ctrl = reg_write && (reg_addr == `ADDR_CONTROL);
	// A soft reset is a one-cycle write pulse; it is not stored.
	assign soft_reset = wr_ctrl && reg_wdata[`BIT_CTRL_SOFT_RESET];

	config_byte_reg #(
		.RESET_VALUE(`RESET_CHANNEL_MODE),
		.WRITE_MASK(`FULL_MASK)
	) u_channel_mode (
		.mclk(mclk),
		.rst(rst),
		.clk_en(clk_en),
		.write_en(wr_mode),
		.locked(locked),
		.soft_reset(soft_reset),
		.write_data(reg_wdata),
		.value(channel_mode_value)
	);

	// Bit 0 is read-only and always reads as one.
	config_byte_reg #(
		.RESET_VALUE(`RESET_ATTEN_FIRST),
		.WRITE_MASK(`ATTEN_FIRST_RW_MASK)
	) u_atten_first (
		.mclk(mclk),
		.rst(rst),
		.clk_en(clk_en),
		.write_en(wr_atten1),
		.locked(locked),
		.soft_reset(soft_reset),
		.write_data(reg_wdata),
		.value(atten_first_value)
	);

	// Reserved bits 3, 7 and 6 are plain storage resetting to zero.
	config_byte_reg #(
		.RESET_VALUE(`RESET_ATTEN_SECOND),
		.WRITE_MASK(`FULL_MASK)
	) u_atten_second (
		.mclk(mclk),
		.rst(rst),
		.clk_en(clk_en),
		.write_en(wr_atten2),
		.locked(locked),
		.soft_reset(soft_reset),
		.write_data(reg_wdata),
		.value(atten_second_value)
	);

	config_byte_reg #(
		.RESET_VALUE(`RESET_ACOUSTICS_FIRST),
		.WRITE_MASK(`FULL_MASK)
	) u_acoustics (
		.mclk(mclk),
		.rst(rst),
		.clk_en(clk_en),
		.write_en(wr_acou),
		.locked(locked),
		.soft_reset(soft_reset),
		.write_data(reg_wdata),
		.value(acoustics_value)
	);

	// ------------------------------------------------------------
	// Lock control
	// ------------------------------------------------------------
	// The lock is sticky until hard reset, so software cannot unlock itself.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			control_value <= `RESET_CONTROL;
		end else if (clk_en) begin
			if (wr_ctrl && reg_wdata[`BIT_CTRL_LOCK]) begin
				control_value[`BIT_CTRL_LOCK] <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			locked <= 1'b0;
		end else if (clk_en) begin
			locked <= control_value[`BIT_CTRL_LOCK] || (wr_ctrl && reg_wdata[`BIT_CTRL_LOCK]);
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	logic [7:0] next_rdata;

	always_comb begin
		unique case (reg_addr)
			`ADDR_CHANNEL_MODE: next_rdata = channel_mode_value;
			`ADDR_ATTEN_FIRST: next_rdata = atten_first_value | `ATTEN_FIRST_RO_VALUE;
			`ADDR_ATTEN_SECOND: next_rdata = atten_second_value;
			`ADDR_ACOUSTICS_FIRST: next_rdata = acoustics_value;
			`ADDR_CONTROL: next_rdata = control_value;
			default: next_rdata = `ZERO_BYTE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= `ZERO_BYTE;
		end else if (clk_en) begin
			if (reg_read) begin
				reg_rdata <= next_rdata;
			end else begin
				reg_rdata <= `ZERO_BYTE;
			end
		end
	end

	// ------------------------------------------------------------
	// Decoded controls
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin5_extra_output_enable <= 1'b0;
			pin6_extra_output_enable <= 1'b0;
			single_channel_mode <= 1'b0;
		end else if (clk_en) begin
			pin5_extra_output_enable <= channel_mode_value[`BIT_PIN5_EXTRA];
			pin6_extra_output_enable <= channel_mode_value[`BIT_PIN6_EXTRA];
			single_channel_mode <= channel_mode_value[`BIT_SINGLE_MODE];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			atten_first_keep <= `RESET_ATTEN_FIRST_KEEP;
			atten_second_keep <= `RESET_ATTEN_SECOND_KEEP;
		end else if (clk_en) begin
			atten_first_keep <= atten_first_value[`ATTEN1_KEEP_HI:`ATTEN1_KEEP_LO];
			atten_second_keep <= {atten_second_value[`ATTEN2_HIGH_HI:`ATTEN2_HIGH_LO],
				atten_second_value[`ATTEN2_LOW_HI:`ATTEN2_LOW_LO]};
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			acoustics_enable_out1 <= 1'b0;
			acoustics_enable_out2 <= 1'b0;
		end else if (clk_en) begin
			acoustics_enable_out1 <= acoustics_value[`BIT_ACOUSTICS_OUT1];
			acoustics_enable_out2 <= acoustics_value[`BIT_ACOUSTICS_OUT2];
		end
	end

	ramp_step_lookup u_ramp_out1 (
		.mclk(mclk),
		.rst(rst),
		.clk_en(clk_en),
		.rate_code(acoustics_value[`RAMP1_HI:`RAMP1_LO]),
		.duty_step(duty_step_out1)
	);

	ramp_step_lookup u_ramp_out2 (
		.mclk(mclk),
		.rst(rst),
		.clk_en(clk_en),
		.rate_code(acoustics_value[`RAMP2_HI:`RAMP2_LO]),
		.duty_step(duty_step_out2)
	);

	// ------------------------------------------------------------
	// Conversion channel sequencing
	// ------------------------------------------------------------
	// Codes 0x0F and above 0x11 name no channel; the sequence skips them and a
	// single-channel selection of such a code falls back to the pin 26 input.
	logic [4:0] selected_code;
	logic [4:0] next_scan;

	always_comb begin
		unique case (channel_mode_value[`SEL_HI:`SEL_LO])
			chan_pin26, chan_12v_first, chan_12v_second, chan_12v_third:
				selected_code = channel_mode_value[`SEL_HI:`SEL_LO];
			chan_remote1, chan_remote2, chan_remote3, chan_local:
				selected_code = channel_mode_value[`SEL_HI:`SEL_LO];
			chan_3v3, chan_pin15, chan_pin19, chan_5v:
				selected_code = channel_mode_value[`SEL_HI:`SEL_LO];
			chan_pin23, chan_pin24, chan_pin25:
				selected_code = channel_mode_value[`SEL_HI:`SEL_LO];
			chan_1v5_first, chan_1v5_second:
				selected_code = channel_mode_value[`SEL_HI:`SEL_LO];
			default:
				selected_code = `FIRST_CHANNEL_CODE;
		endcase
	end

	always_comb begin
		if (convert_channel >= `LAST_CHANNEL_CODE) begin
			next_scan = `FIRST_CHANNEL_CODE;
		end else if (convert_channel == chan_pin25) begin
			next_scan = chan_1v5_first;
		end else begin
			next_scan = convert_channel + 5'h01;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			convert_channel <= `FIRST_CHANNEL_CODE;
		end else if (clk_en) begin
			if (channel_mode_value[`BIT_SINGLE_MODE]) begin
				convert_channel <= selected_code;
			end else if (seq_advance) begin
				convert_channel <= next_scan;
			end
		end
	end
endmodule

/* testbench/monitor_cfg_checker.sv */
// Concurrent checks on the channel and acoustics configuration group.
// Assumes it is bound to the top module; checks are skipped while clk_en is low.
`timescale 1ns/100ps
module monitor_cfg_checker (
	// Clock and reset
	input logic mclk,
	input logic rst,
	input logic clk_en,
	// Register port
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic reg_write,
	input logic reg_read,
	input logic [7:0] reg_rdata,
	// Decoded outputs
	input logic single_channel_mode,
	input logic [4:0] convert_channel,
	input logic pin5_extra_output_enable,
	input logic pin6_extra_output_enable,
	input logic [6:0] atten_first_keep,
	input logic [4:0] atten_second_keep,
	input logic acoustics_enable_out1,
	input logic acoustics_enable_out2,
	input monitor_cfg_pkg::duty_step_type duty_step_out1,
	input monitor_cfg_pkg::duty_step_type duty_step_out2,
	input logic locked
);
	import monitor_cfg_pkg::*;
	localparam logic [5:0] STEP [8] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h08, 6'h0C, 6'h18, 6'h30};
	logic wr_open;
	logic sel_ok;
	assign wr_open = reg_write && !locked;
	assign sel_ok = reg_wdata[7:3] != 5'h0F && reg_wdata[7:3] <= 5'h11;
	// A frozen clock enable aborts every check in flight.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst || !clk_en);
	mode_bits_a: assert property (
		wr_open && reg_addr == 8'h16 |-> ##2 {single_channel_mode, pin6_extra_output_enable,
		pin5_extra_output_enable} == $past(reg_wdata[2:0], 2)) else $error("mode bits wrong");
	single_chan_a: assert property (
		wr_open && reg_addr == 8'h16 && reg_wdata[2] |-> ##2
		convert_channel == ($past(sel_ok, 2) ? $past(reg_wdata[7:3], 2) : 5'h00))
		else $error("single channel wrong");
	atten_first_a: assert property (
		wr_open && reg_addr == 8'h18 |-> ##2 atten_first_keep == $past(reg_wdata[7:1], 2))
		else $error("first attenuators wrong");
	atten_second_a: assert property (
		wr_open && reg_addr == 8'h19 |-> ##2
		atten_second_keep == {$past(reg_wdata[5:4], 2), $past(reg_wdata[2:0], 2)})
		else $error("second attenuators wrong");
	fan_enable_a: assert property (
		wr_open && reg_addr == 8'h1A |-> ##2 {acoustics_enable_out2, acoustics_enable_out1}
		== $past(reg_wdata[1:0], 2)) else $error("acoustics enables wrong");
	ramp_step_a: assert property (
		wr_open && reg_addr == 8'h1A |-> ##2 duty_step_out1 == STEP[$past(reg_wdata[4:2], 2)]
		&& duty_step_out2 == STEP[$past(reg_wdata[7:5], 2)]) else $error("duty step wrong");
	lock_hold_a: assert property (
		locked && reg_write && reg_addr != 8'h30 |-> ##2 $stable(atten_first_keep)
		&& $stable(atten_second_keep) && $stable(duty_step_out2)) else $error("locked write taken");
	soft_reset_a: assert property (
		reg_write && reg_addr == 8'h30 && reg_wdata[1] |-> ##2 atten_first_keep == 7'h7F
		&& atten_second_keep == 5'h1F && duty_step_out1 == 6'h01 && duty_step_out2 == 6'h01
		&& !single_channel_mode && !acoustics_enable_out1 && !pin5_extra_output_enable)
		else $error("soft reset defaults wrong");
	atten_ro_bit_a: assert property (
		reg_read && reg_addr == 8'h18 |=> reg_rdata[0]) else $error("reserved bit not one");
endmodule

bind monitor_channel_acoustics_config monitor_cfg_checker chk (.mclk, .rst, .clk_en, .reg_addr,
	.reg_wdata, .reg_write, .reg_read, .reg_rdata, .single_channel_mode, .convert_channel,
	.pin5_extra_output_enable,
	.pin6_extra_output_enable, .atten_first_keep, .atten_second_keep, .acoustics_enable_out1,
	.acoustics_enable_out2, .duty_step_out1, .duty_step_out2, .locked);

/* testbench/testbench.sv */
// Self-checking bench for the channel and acoustics configuration group.
// Assumes the bound checker; clk_en drops once to show that a frozen write is lost.
`timescale 1ns/100ps
module testbench;
	import monitor_cfg_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic seq_advance = 1'b0;
	byte_type reg_rdata;
	logic single_channel_mode;
	logic [4:0] convert_channel;
	logic pin5_extra_output_enable;
	logic pin6_extra_output_enable;
	logic [6:0] atten_first_keep;
	logic [4:0] atten_second_keep;
	logic acoustics_enable_out1;
	logic acoustics_enable_out2;
	duty_step_type duty_step_out1;
	duty_step_type duty_step_out2;
	logic locked;
	int fail_count = 0;
	int samples_checked = 0;
	logic [5:0] steps [8] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h08, 6'h0C, 6'h18, 6'h30};
	logic [4:0] ch;
	always #20 mclk = ~mclk;
	monitor_channel_acoustics_config uut (.mclk, .rst, .clk_en, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata, .seq_advance, .single_channel_mode, .convert_channel,
		.pin5_extra_output_enable, .pin6_extra_output_enable, .atten_first_keep,
		.atten_second_keep, .acoustics_enable_out1, .acoustics_enable_out2, .duty_step_out1,
		.duty_step_out2, .locked);
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// Waits two more edges so that the decoded outputs have caught up.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_write <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_read <= 1'b0;
		@(posedge mclk);
		check(reg_rdata, exp);
	endtask
	task automatic adv();
		@(posedge mclk);
		seq_advance <= 1'b1;
		@(posedge mclk);
		seq_advance <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		#200000;
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd(8'h16, 8'h00);
		rd(8'h18, 8'hFF);
		rd(8'h19, 8'h37);
		rd(8'h1A, 8'h00);
		rd(8'h17, 8'h00);
		check({3'b0, atten_second_keep}, 8'h1F);
		wr(8'h18, 8'h00);
		rd(8'h18, 8'h01);
		check({1'b0, atten_first_keep}, 8'h00);
		wr(8'h19, 8'hCA);
		rd(8'h19, 8'hCA);
		check({3'b0, atten_second_keep}, 8'h02);
		for (int i = 0; i < 8; i++) begin
			wr(8'h1A, {i[2:0], ~i[2:0], i[1:0]});
			check({2'b0, duty_step_out1}, {2'b0, steps[~i[2:0]]});
			check({2'b0, duty_step_out2}, {2'b0, steps[i[2:0]]});
			check({6'h00, acoustics_enable_out2, acoustics_enable_out1}, {6'h00, i[1:0]});
		end
		for (int c = 0; c < 19; c++) begin
			wr(8'h16, {c[4:0], 3'b111});
			ch = (c == 15 || c > 17) ? 5'h00 : c[4:0];
			check({3'b0, convert_channel}, {3'b0, ch});
			check({5'b0, single_channel_mode, pin6_extra_output_enable,
				pin5_extra_output_enable}, 8'h07);
			rd(8'h16, {c[4:0], 3'b111});
		end
		wr(8'h16, 8'h5C);
		adv();
		check({3'b0, convert_channel}, 8'h0B);
		wr(8'h30, 8'h01);
		check({7'b0, locked}, 8'h01);
		wr(8'h1A, 8'hFF);
		rd(8'h1A, 8'hE3);
		wr(8'h30, 8'h02);
		rd(8'h19, 8'h37);
		rd(8'h1A, 8'h00);
		rd(8'h30, 8'h01);
		check({1'b0, atten_first_keep}, 8'h7F);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		clk_en <= 1'b0;
		wr(8'h19, 8'h00);
		clk_en <= 1'b1;
		rd(8'h19, 8'h37);
		wr(8'h16, 8'h48);
		ch = 5'h00;
		repeat (18) begin
			adv();
			ch = (ch == 5'h0E) ? 5'h10 : (ch == 5'h11) ? 5'h00 : ch + 5'h01;
			check({3'b0, convert_channel}, {3'b0, ch});
		end
		end_sim();
	end
endmodule
